// file: rtl/usb_ep_cfg_pkg.sv
// Purpose: Shared constants for the endpoint configuration block
// Assumes: 32-bit classic Wishbone, byte addresses on an 8-bit address
// Notes: Configuration words are 16 bits wide in the low half of a bus word
package usb_ep_cfg_pkg;
  // Register map, byte offsets
  localparam logic [7:0] OFF_RX_BASE = 8'h00;  // Receive configs, word n = endpoint n
  localparam logic [7:0] OFF_TX_BASE = 8'h40;  // Transmit configs, word n = endpoint n
  localparam logic [7:0] OFF_SYSCTL = 8'h80;   // System control one (lock)
  localparam logic [7:0] OFF_STATUS = 8'h84;   // Sticky event status, read only
  localparam logic [7:0] OFF_CLEAR = 8'h88;    // Write one to clear status, write only
  localparam logic [7:0] OFF_ENABLE = 8'h8C;   // Interrupt enable
  // Configuration word fields
  localparam int VALID_BIT = 15;
  localparam int DBSZ_BIT = 14;
  localparam int SIZE_LO = 12;
  localparam int ISO_BIT = 11;
  localparam int PTR_W = 11;
  localparam int CFG_W = 16;
  localparam int PTR_SHIFT = 3;               // Pointer counts 8-byte steps
  localparam int ADDR_W = PTR_W + PTR_SHIFT;  // Buffer byte address width
  localparam int SIZE_W = 11;                 // Byte size, up to 1023
  localparam logic [SIZE_W-1:0] MIN_BYTES = 11'h008;
  localparam logic [SIZE_W-1:0] ISO_MAX_BYTES = 11'h3FF;
  localparam logic [2:0] ISO_MAX_CODE = 3'h7;
  localparam logic [PTR_W-1:0] PTR_SETUP = 11'h000;  // Held by the setup FIFO
  // System control bits
  localparam int LOCK_BIT = 0;
  // Event bits of status, clear and enable
  localparam int EV_DONE = 0;     // Non-isochronous transaction needs software
  localparam int EV_SOF = 1;      // Isochronous activity reported at frame start
  localparam int EV_UNDER = 2;    // Transmit FIFO read while empty
  localparam int EV_OVER = 3;     // Receive FIFO written while full
  localparam int EV_IGNORED = 4;  // Transaction to an endpoint not configured
  localparam int EV_LOCKWR = 5;   // Configuration write refused under lock
  localparam int EV_W = 6;
  // Transaction tracker states, one-hot
  typedef enum logic [1:0] {
    TRX_IDLE = 2'b01,
    TRX_BUSY = 2'b10
  } trx_state_e;
endpackage : usb_ep_cfg_pkg

// file: rtl/usb_ep_size_decode.sv
// Purpose: Decodes an endpoint's size code and buffering mode
// Assumes: Fields already selected for the endpoint in use
// Notes: Pure combinational; the caller registers the results
`timescale 1ns/100ps
module usb_ep_size_decode (
  // Configuration fields
  input wire logic iso,
  input wire logic dbsz,
  input wire logic [1:0] size,
  // Direction and service mode
  input wire logic is_tx,
  input wire logic dma,
  // Decoded results
  output logic [usb_ep_cfg_pkg::SIZE_W-1:0] bytes,
  output logic dbl
);
  // Isochronous uses the extra bit as size MSB, others never
  wire [2:0] code = iso ? {dbsz, size} : {1'b0, size};  // RULE11 RULE12
  wire top = iso && (code == usb_ep_cfg_pkg::ISO_MAX_CODE);

  // Top code is 1023, not 1024: it must fit the whole buffer memory
  assign bytes = top ? usb_ep_cfg_pkg::ISO_MAX_BYTES : (usb_ep_cfg_pkg::MIN_BYTES << code);  // RULE12

  // Isochronous always ping-pongs; transmit only doubles under DMA
  assign dbl = iso || (dbsz && (!is_tx || dma));  // RULE10 RULE18
endmodule : usb_ep_size_decode

// file: rtl/usb_endpoint_config.sv
// Purpose: Per-endpoint receive and transmit configuration with transaction steering
// Assumes: One clock; transaction engine and FIFO counter share it
// Notes: Fields other than valid have no reset and read unknown until written
// Contract
// RULE1 - Receive bit 11 set means isochronous
// RULE2 - Type bit set is isochronous, clear is not
// RULE3 - Receive pointer 8-byte steps; zero not allowed
// RULE4 - Software keeps every pointer below 0xFF
// RULE5 - Software reserves twice size for ping-pong
// RULE6 - Configure all fields before lock, then freeze
// RULE7 - Sizes must match those reported to host
// RULE8 - Transmit valid clear: transactions ignored
// RULE9 - Valid cleared by hardware reset only
// RULE10 - Transmit double buffer only non-iso DMA
// RULE11 - Non-iso size code 8 to 64 bytes
// RULE12 - Iso three-bit size, top code 1023
// RULE13 - Transmit FIFO flags, underrun from size
// RULE14 - Transmit bit 11 set means isochronous
// RULE15 - Transmit pointer locates buffer in 8-byte steps
// RULE16 - Interrupt at transaction end; iso at frame
// RULE17 - Receive valid clear: transactions ignored
// RULE18 - Receive bit 14 double buffer or MSB
// RULE19 - Endpoints 1 to 15 each direction
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
module usb_endpoint_config #(
  parameter int NUM_EP = 16  // Endpoint numbers 0..NUM_EP-1, 0 is control
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Bus reset seen by the serial engine
  input wire logic USB_BUS_RESET,
  // Wishbone slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  // Transaction requests from the serial engine
  input wire logic TRX_START,
  input wire logic TRX_END,
  input wire logic [3:0] TRX_EP,
  input wire logic TRX_DIR_IN,
  input wire logic TRX_DMA,
  input wire logic TRX_WORK,
  input wire logic SOF,
  // FIFO occupancy of the endpoint in use
  input wire logic [usb_ep_cfg_pkg::SIZE_W-1:0] FIFO_COUNT,
  input wire logic FIFO_STROBE,
  // Transaction steering
  output logic TRX_ACCEPT,
  output logic TRX_ISO,
  output logic TRX_DOUBLE_BUF,
  output logic [usb_ep_cfg_pkg::SIZE_W-1:0] TRX_FIFO_SIZE,
  output logic [usb_ep_cfg_pkg::ADDR_W-1:0] TRX_BUF_ADDR,
  output logic FIFO_EMPTY,
  output logic FIFO_FULL,
  // Software visibility
  output logic CFG_LOCKED,
  output logic IRQ
);
  localparam int CW = usb_ep_cfg_pkg::CFG_W;
  localparam int SW = usb_ep_cfg_pkg::SIZE_W;
  localparam int EW = usb_ep_cfg_pkg::EV_W;
  // Refuse endpoint counts the 4-bit endpoint number cannot reach
  if (NUM_EP < 2 || NUM_EP > 16) begin : g_bad_num_ep
    $error("NUM_EP must lie in 2..16");
  end
  // Stored configuration; valid bits live apart so they can be reset
  logic [CW-2:0] rx_cfg_ff [1:NUM_EP-1];  // No reset: kept over both resets
  logic [CW-2:0] tx_cfg_ff [1:NUM_EP-1];
  logic [NUM_EP-1:1] rx_valid_ff;
  logic [NUM_EP-1:1] tx_valid_ff;
  // Bus side state
  logic ack_ff;
  logic [31:0] dat_ff;
  logic lock_ff;
  logic [EW-1:0] status_ff;
  logic [EW-1:0] enable_ff;
  // Transaction side state
  usb_ep_cfg_pkg::trx_state_e state_ff;
  logic accept_ff;
  logic iso_ff;
  logic dbl_ff;
  logic dir_in_ff;
  logic [SW-1:0] size_ff;
  logic [usb_ep_cfg_pkg::ADDR_W-1:0] addr_ff;
  logic empty_ff;
  logic full_ff;
  logic iso_seen_ff;  // Isochronous traffic since the last frame start
  // Bus decode; a write is taken at the edge that sees ack high, read data one edge earlier
  wire req = WB_CYC && WB_STB;
  wire wr = req && ack_ff && WB_WE;
  wire [3:0] ep_a = WB_ADR[5:2];
  wire ep_a_ok = (ep_a != 4'h0) && (32'(ep_a) < NUM_EP);  // RULE19
  wire hit_rx = (WB_ADR[7:6] == usb_ep_cfg_pkg::OFF_RX_BASE[7:6]) && ep_a_ok;
  wire hit_tx = (WB_ADR[7:6] == usb_ep_cfg_pkg::OFF_TX_BASE[7:6]) && ep_a_ok;
  wire hit_sys = WB_ADR == usb_ep_cfg_pkg::OFF_SYSCTL;
  wire hit_stat = WB_ADR == usb_ep_cfg_pkg::OFF_STATUS;
  wire hit_clr = WB_ADR == usb_ep_cfg_pkg::OFF_CLEAR;
  wire hit_en = WB_ADR == usb_ep_cfg_pkg::OFF_ENABLE;
  // Writes under lock are dropped so the engine never sees a torn setup
  wire cfg_wr = wr && (hit_rx || hit_tx);
  wire cfg_wr_ok = cfg_wr && !lock_ff;  // RULE6
  wire [CW-1:0] lane_mask = {{8{WB_SEL[1]}}, {8{WB_SEL[0]}}};
  // Readback selection; unmapped and write-only addresses read zero
  wire [CW-1:0] rx_rd = {rx_valid_ff[ep_a], rx_cfg_ff[ep_a]};
  wire [CW-1:0] tx_rd = {tx_valid_ff[ep_a], tx_cfg_ff[ep_a]};
  wire [31:0] rd_word = hit_rx ? {16'h0000, rx_rd} :
                        hit_tx ? {16'h0000, tx_rd} :
                        hit_sys ? {31'h0000_0000, lock_ff} :
                        hit_stat ? {{(32-EW){1'b0}}, status_ff} :
                        hit_en ? {{(32-EW){1'b0}}, enable_ff} : 32'h0000_0000;
  // Ack comes one cycle after the request and drops the cycle after
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req && !ack_ff;
      if (req && !ack_ff) begin
        dat_ff <= rd_word;
      end
    end
  end
  // Per-endpoint storage, merged byte lane by byte lane
  for (genvar i = 1; i < NUM_EP; i++) begin : g_ep
    wire wr_rx = cfg_wr_ok && hit_rx && (32'(ep_a) == i);
    wire wr_tx = cfg_wr_ok && hit_tx && (32'(ep_a) == i);
    wire [CW-1:0] nxt_rx = (WB_DAT_I[CW-1:0] & lane_mask) | ({rx_valid_ff[i], rx_cfg_ff[i]} & ~lane_mask);
    wire [CW-1:0] nxt_tx = (WB_DAT_I[CW-1:0] & lane_mask) | ({tx_valid_ff[i], tx_cfg_ff[i]} & ~lane_mask);

    // Fields: no reset at all, bus reset included
    always_ff @(posedge CLK) begin
      if (wr_rx) begin
        rx_cfg_ff[i] <= nxt_rx[CW-2:0];
      end
      if (wr_tx) begin
        tx_cfg_ff[i] <= nxt_tx[CW-2:0];
      end
    end

    // Valid: hardware reset only; bus reset does not touch it
    always_ff @(posedge CLK) begin
      if (SRST) begin  // RULE9
        rx_valid_ff[i] <= 1'b0;
        tx_valid_ff[i] <= 1'b0;
      end else begin
        if (wr_rx) begin
          rx_valid_ff[i] <= nxt_rx[usb_ep_cfg_pkg::VALID_BIT];
        end
        if (wr_tx) begin
          tx_valid_ff[i] <= nxt_tx[usb_ep_cfg_pkg::VALID_BIT];
        end
      end
    end
  end
  // Configuration of the endpoint named by a starting transaction
  wire ep_t_ok = (TRX_EP != 4'h0) && (32'(TRX_EP) < NUM_EP);  // RULE19
  wire [CW-2:0] sel_cfg = TRX_DIR_IN ? tx_cfg_ff[TRX_EP] : rx_cfg_ff[TRX_EP];
  wire sel_valid = ep_t_ok && (TRX_DIR_IN ? tx_valid_ff[TRX_EP] : rx_valid_ff[TRX_EP]);  // RULE8 RULE17
  wire [usb_ep_cfg_pkg::PTR_W-1:0] sel_ptr = sel_cfg[usb_ep_cfg_pkg::PTR_W-1:0];
  wire ptr_ok = TRX_DIR_IN || (sel_ptr != usb_ep_cfg_pkg::PTR_SETUP);  // RULE3
  wire accept = sel_valid && ptr_ok;
  // Set bit means isochronous; the inverted encoding is not supported
  wire sel_iso = sel_cfg[usb_ep_cfg_pkg::ISO_BIT];  // RULE1 RULE2 RULE14
  wire [SW-1:0] sel_bytes;
  wire sel_dbl;

  usb_ep_size_decode u_size (
    .iso(sel_iso),
    .dbsz(sel_cfg[usb_ep_cfg_pkg::DBSZ_BIT]),
    .size(sel_cfg[usb_ep_cfg_pkg::SIZE_LO+1:usb_ep_cfg_pkg::SIZE_LO]),
    .is_tx(TRX_DIR_IN),
    .dma(TRX_DMA),
    .bytes(sel_bytes),
    .dbl(sel_dbl)
  );
  // Event sources
  wire idle = state_ff == usb_ep_cfg_pkg::TRX_IDLE;
  wire busy = state_ff == usb_ep_cfg_pkg::TRX_BUSY;
  wire start = idle && TRX_START;
  wire fin = busy && (TRX_END || USB_BUS_RESET);
  wire ev_under = busy && dir_in_ff && FIFO_STROBE && (FIFO_COUNT == '0);  // RULE13
  wire ev_over = busy && !dir_in_ff && FIFO_STROBE && full_ff;
  wire ev_done = busy && TRX_END && !iso_ff && TRX_WORK;  // RULE16
  wire ev_sof = SOF && iso_seen_ff;  // RULE16
  wire [EW-1:0] ev = {cfg_wr && lock_ff, start && !accept, ev_over, ev_under, ev_sof, ev_done};
  wire [EW-1:0] clr = (wr && hit_clr && WB_SEL[0]) ? WB_DAT_I[EW-1:0] : '0;
  // A new event in the clearing cycle survives the clear
  wire [EW-1:0] nxt_status = (status_ff & ~clr) | ev;
  // Lock, status and enable registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      lock_ff <= 1'b0;
      status_ff <= '0;
      enable_ff <= '0;
    end else begin
      status_ff <= nxt_status;
      if (wr && hit_sys && WB_SEL[0]) begin
        lock_ff <= WB_DAT_I[usb_ep_cfg_pkg::LOCK_BIT];
      end
      if (wr && hit_en && WB_SEL[0]) begin
        enable_ff <= WB_DAT_I[EW-1:0];
      end
    end
  end
  // Transaction tracker: latches steering at start, holds until end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_ff <= usb_ep_cfg_pkg::TRX_IDLE;
      accept_ff <= 1'b0;
      iso_ff <= 1'b0;
      dbl_ff <= 1'b0;
      dir_in_ff <= 1'b0;
      size_ff <= '0;
      addr_ff <= '0;
    end else begin
      case (state_ff)
        usb_ep_cfg_pkg::TRX_IDLE: begin
          if (TRX_START && accept && !USB_BUS_RESET) begin
            state_ff <= usb_ep_cfg_pkg::TRX_BUSY;
            accept_ff <= 1'b1;
            iso_ff <= sel_iso;
            dbl_ff <= sel_dbl;
            dir_in_ff <= TRX_DIR_IN;
            size_ff <= sel_bytes;  // RULE11 RULE12
            addr_ff <= {sel_ptr, {usb_ep_cfg_pkg::PTR_SHIFT{1'b0}}};  // RULE15 RULE3
          end else begin
            accept_ff <= 1'b0;
          end
        end
        usb_ep_cfg_pkg::TRX_BUSY: begin
          if (fin) begin
            state_ff <= usb_ep_cfg_pkg::TRX_IDLE;
            accept_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= usb_ep_cfg_pkg::TRX_IDLE;
          accept_ff <= 1'b0;
        end
      endcase
    end
  end
  // FIFO flags follow the configured size only while a transaction runs
  always_ff @(posedge CLK) begin
    if (SRST || !busy) begin
      empty_ff <= 1'b1;
      full_ff <= 1'b0;
    end else begin
      empty_ff <= FIFO_COUNT == '0;  // RULE13
      full_ff <= FIFO_COUNT >= size_ff;  // RULE13
    end
  end
  // Isochronous ends are held back and reported at the next frame start
  always_ff @(posedge CLK) begin
    if (SRST) begin
      iso_seen_ff <= 1'b0;
    end else if (busy && TRX_END && iso_ff) begin
      iso_seen_ff <= 1'b1;
    end else if (SOF) begin
      iso_seen_ff <= 1'b0;
    end
  end
  // Outputs
  assign WB_ACK = ack_ff;
  assign WB_DAT_O = dat_ff;
  assign TRX_ACCEPT = accept_ff;
  assign TRX_ISO = iso_ff;
  assign TRX_DOUBLE_BUF = dbl_ff;
  assign TRX_FIFO_SIZE = size_ff;
  assign TRX_BUF_ADDR = addr_ff;
  assign FIFO_EMPTY = empty_ff;
  assign FIFO_FULL = full_ff;
  assign CFG_LOCKED = lock_ff;
  assign IRQ = |(status_ff & enable_ff);
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_start_ok;
    idle && TRX_START && accept && !USB_BUS_RESET;
  endsequence
  sequence s_start_bad_dir(logic dir);
    idle && TRX_START && (TRX_DIR_IN == dir) && !sel_valid;
  endsequence
  property p_tx_invalid;
    s_start_bad_dir(1'b1) |=> !TRX_ACCEPT ##1 status_ff[usb_ep_cfg_pkg::EV_IGNORED];
  endproperty
  a_tx_invalid: assert property (p_tx_invalid) else $error("Invalid transmit endpoint accepted");  // RULE8
  property p_rx_invalid;
    s_start_bad_dir(1'b0) |=> !TRX_ACCEPT;
  endproperty
  a_rx_invalid: assert property (p_rx_invalid) else $error("Invalid receive endpoint accepted");  // RULE17
  property p_rx_ptr_zero;
    idle && TRX_START && !TRX_DIR_IN && (sel_ptr == usb_ep_cfg_pkg::PTR_SETUP) |=> !TRX_ACCEPT;
  endproperty
  a_rx_ptr_zero: assert property (p_rx_ptr_zero) else $error("Receive pointer zero accepted");  // RULE3
  property p_bus_reset_keeps;
    USB_BUS_RESET && !cfg_wr |=> (rx_valid_ff == $past(rx_valid_ff)) && (tx_valid_ff == $past(tx_valid_ff));
  endproperty
  a_bus_reset_keeps: assert property (p_bus_reset_keeps) else $error("Bus reset changed a valid bit");  // RULE9
  property p_hw_reset_clears;
    @(posedge CLK) disable iff (1'b0) SRST |=> (rx_valid_ff == '0) && (tx_valid_ff == '0);
  endproperty
  a_hw_reset_clears: assert property (p_hw_reset_clears) else $error("Valid bits survived reset");  // RULE9
  property p_noniso_size;
    s_start_ok and !sel_iso |=> $onehot(TRX_FIFO_SIZE) && TRX_FIFO_SIZE >= 11'h008 && TRX_FIFO_SIZE <= 11'h040;
  endproperty
  a_noniso_size: assert property (p_noniso_size) else $error("Non-isochronous size out of range");  // RULE11
  property p_iso_top;
    s_start_ok and sel_iso && sel_cfg[14:12] == 3'h7 |=> TRX_FIFO_SIZE == 11'h3FF && TRX_DOUBLE_BUF;
  endproperty
  a_iso_top: assert property (p_iso_top) else $error("Isochronous top size not 1023");  // RULE12
  property p_tx_no_dma_single;
    s_start_ok and TRX_DIR_IN && !sel_iso && !TRX_DMA |=> !TRX_DOUBLE_BUF;
  endproperty
  a_tx_no_dma_single: assert property (p_tx_no_dma_single) else $error("Double buffer without DMA");  // RULE10
  property p_buf_addr;
    s_start_ok |=> TRX_BUF_ADDR == {$past(sel_ptr), 3'b000} && TRX_ACCEPT;
  endproperty
  a_buf_addr: assert property (p_buf_addr) else $error("Buffer address not pointer times 8");  // RULE15
  property p_underrun;
    busy && dir_in_ff && FIFO_STROBE && FIFO_COUNT == '0 |=> status_ff[usb_ep_cfg_pkg::EV_UNDER];
  endproperty
  a_underrun: assert property (p_underrun) else $error("Underrun not flagged");  // RULE13
  property p_iso_at_sof;
    busy && TRX_END && iso_ff && !SOF |=> iso_seen_ff && !$rose(status_ff[usb_ep_cfg_pkg::EV_DONE]);
  endproperty
  a_iso_at_sof: assert property (p_iso_at_sof) else $error("Isochronous end reported early");  // RULE16
endmodule : usb_endpoint_config

// file: test/usb_trx_model.sv
// Purpose: Serial engine stand-in that raises transaction strobes
// Assumes: Same clock as the block; changes land just after a rising edge
// Notes: Endpoint number is scrambled once taken, so a late sample shows
`timescale 1ns/100ps
module usb_trx_model (
  // Clock
  input wire logic CLK,
  // Transaction strobes and qualifiers
  output logic TRX_START,
  output logic TRX_END,
  output logic [3:0] TRX_EP,
  output logic TRX_DIR_IN,
  output logic TRX_DMA,
  output logic TRX_WORK,
  // Frame marker
  output logic SOF
);
  // Quiet levels from time zero
  initial begin
    TRX_START = 1'b0;
    TRX_END = 1'b0;
    TRX_EP = 4'h0;
    TRX_DIR_IN = 1'b0;
    TRX_DMA = 1'b0;
    TRX_WORK = 1'b0;
    SOF = 1'b0;
  end
  // One-cycle start; direction and service mode held for the transfer
  task automatic begin_trx(input logic [3:0] ep, input logic dir_in, input logic dma);
    @(posedge CLK);
    TRX_START <= 1'b1;
    TRX_EP <= ep;
    TRX_DIR_IN <= dir_in;
    TRX_DMA <= dma;
    @(posedge CLK);
    TRX_START <= 1'b0;
    TRX_EP <= ~ep;
  endtask : begin_trx
  // End pulse; the work flag is only meaningful with it
  task automatic end_trx(input logic work);
    @(posedge CLK);
    TRX_END <= 1'b1;
    TRX_WORK <= work;
    @(posedge CLK);
    TRX_END <= 1'b0;
    TRX_WORK <= ~work;
  endtask : end_trx
  // Start of frame pulse
  task automatic frame();
    @(posedge CLK);
    SOF <= 1'b1;
    @(posedge CLK);
    SOF <= 1'b0;
  endtask : frame
endmodule : usb_trx_model

// file: test/usb_endpoint_config_tb.sv
// Purpose: Self-checking bench for the endpoint configuration block
// Assumes: 200 MHz clock, classic Wishbone master, serial engine model
// Notes: Pointers, service mode and work flag come from a fixed xorshift
`timescale 1ns/100ps
module usb_endpoint_config_tb;
  // Clock, resets and bus master
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic bus_rst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [3:0] wsel = 4'hF;  // Byte enables for the next bus cycle
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o, rd;
  logic ack;
  // FIFO side, driven by the bench
  logic [10:0] fcnt = 11'h000;
  logic fstb = 1'b0;
  // Engine strobes and block outputs
  logic t_start, t_end, t_in, t_dma, t_work, sof, acc, iso, dbl, empty, full, locked, irq;
  logic [3:0] t_ep;
  logic [10:0] fsize;
  logic [13:0] baddr;
  // Bookkeeping
  logic [15:0] shadow [32];  // Last written word, index {tx, ep}
  logic [5:0] en = 6'h00;  // Enable register as written
  logic [31:0] seed = 32'h0000_002D;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  usb_endpoint_config #(.NUM_EP(16)) u_usb_endpoint_config (.CLK(clk), .SRST(srst), .USB_BUS_RESET(bus_rst),
    .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK(ack), .TRX_START(t_start), .TRX_END(t_end), .TRX_EP(t_ep), .TRX_DIR_IN(t_in), .TRX_DMA(t_dma),
    .TRX_WORK(t_work), .SOF(sof), .FIFO_COUNT(fcnt), .FIFO_STROBE(fstb), .TRX_ACCEPT(acc), .TRX_ISO(iso),
    .TRX_DOUBLE_BUF(dbl), .TRX_FIFO_SIZE(fsize), .TRX_BUF_ADDR(baddr), .FIFO_EMPTY(empty), .FIFO_FULL(full),
    .CFG_LOCKED(locked), .IRQ(irq));
  usb_trx_model u_usb_trx_model (.CLK(clk), .TRX_START(t_start), .TRX_END(t_end), .TRX_EP(t_ep),
    .TRX_DIR_IN(t_in), .TRX_DMA(t_dma), .TRX_WORK(t_work), .SOF(sof));
  // Verdict and end of run
  task automatic final_report();
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Hang guard, well above the thousand or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  // Single comparison point
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Size in bytes: top isochronous code is 1023, not 1024
  function automatic logic [10:0] exp_size(input logic i, input logic [2:0] c);
    if (i)
      return (c == 3'h7) ? 11'h3FF : (11'h008 << c);
    return 11'h008 << c[1:0];
  endfunction : exp_size
  // Classic cycle; holds everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= wsel;
    dat_i <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Status read, interrupt level, then clear all events
  task automatic st(input logic [5:0] e);
    wb(1'b0, 8'h84, 32'h0000_0000);
    chk("status", rd, {26'h000_0000, e});
    chk("irq", irq, |(e & en));
    wb(1'b1, 8'h88, 32'h0000_003F);
    @(posedge clk);
    chk("irq cleared", irq, 1'b0);
  endtask : st
  // Program, start, steer, fill, drain and end one transaction
  task automatic trx(input logic [3:0] ep, input logic tx, input logic [15:0] w, input logic dma, input logic work);
    logic ok;
    logic [5:0] e;
    logic [7:0] a;
    a = (tx ? 8'h40 : 8'h00) + {2'b00, ep, 2'b00};
    e = 6'h00;
    ok = (ep != 4'h0) & w[15] & (tx | (w[10:0] != 11'h000));
    wb(1'b1, a, {16'h0000, w});
    if (ep != 4'h0)
      shadow[{tx, ep}] = w;
    wb(1'b0, a, 32'h0000_0000);
    chk("cfg readback", rd, (ep == 4'h0) ? 32'h0000_0000 : {16'h0000, w});
    u_usb_trx_model.begin_trx(ep, tx, dma);
    @(posedge clk);
    chk("accept", acc, ok);
    if (ok) begin
      chk("iso", iso, w[11]);
      chk("size", fsize, exp_size(w[11], w[14:12]));
      chk("double", dbl, w[11] | (w[14] & (~tx | dma)));
      chk("addr", baddr, {w[10:0], 3'b000});
      fcnt <= exp_size(w[11], w[14:12]);
      repeat (2) @(posedge clk);
      chk("flags at size", {empty, full}, 2'b01);
      fstb <= 1'b1;
      @(posedge clk);
      fstb <= 1'b0;
      fcnt <= 11'h000;
      repeat (2) @(posedge clk);
      chk("flags at zero", {empty, full}, 2'b10);
      fstb <= 1'b1;
      @(posedge clk);
      fstb <= 1'b0;
      u_usb_trx_model.end_trx(work);
      @(posedge clk);
      chk("accept after end", acc, 1'b0);
      u_usb_trx_model.frame();
      e = {2'b00, ~tx, tx, w[11], ~w[11] & work};
    end else
      e[4] = 1'b1;
    st(e);
  endtask : trx
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("reset outputs", {acc, empty, full, locked, irq}, 5'b01000);
    wb(1'b0, 8'h44, 32'h0000_0000);
    chk("valid after reset", rd[15], 1'b0);
    en = 6'h3F;
    wb(1'b1, 8'h8C, {26'h000_0000, en});
    wb(1'b0, 8'h8C, 32'h0000_0000);
    chk("enable", rd, 32'h0000_003F);
    // Every size code in both directions and both types is started; those with valid clear or receive pointer zero are refused
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      w = {(i % 7) != 3, i[2:0], i[3], 11'h000};
      w[10:0] = (i % 9 == 4) ? 11'h000 : ({4'h0, r[6:0]} + 11'h001);
      trx(4'(i % 15 + 1), i[4], w, r[8], r[9]);
    end
    // Masked interrupt, endpoint zero and unmapped space
    en = 6'h00;
    wb(1'b1, 8'h8C, 32'h0000_0000);
    trx(4'h0, 1'b1, 16'h8008, 1'b0, 1'b0);
    en = 6'h3F;
    wb(1'b1, 8'h8C, 32'h0000_003F);
    wb(1'b1, 8'h84, 32'h0000_003F);
    wb(1'b0, 8'h88, 32'h0000_0000);
    chk("clear reads zero", rd, 32'h0000_0000);
    wb(1'b0, 8'h90, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    st(6'h00);
    // Writes under lock leave the configuration alone
    wb(1'b1, 8'h80, 32'h0000_0001);
    @(posedge clk);
    chk("locked", locked, 1'b1);
    wb(1'b1, 8'h44, 32'h0000_1234);
    wb(1'b0, 8'h44, 32'h0000_0000);
    chk("locked cfg", rd, {16'h0000, shadow[17]});
    st(6'h20);
    wb(1'b1, 8'h80, 32'h0000_0000);
    // Bus reset aborts but keeps valid; hardware reset clears valid only
    u_usb_trx_model.begin_trx(4'h1, 1'b1, 1'b0);
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    @(posedge clk);
    chk("bus reset abort", acc, 1'b0);
    wb(1'b0, 8'h44, 32'h0000_0000);
    chk("cfg after bus reset", rd, {16'h0000, shadow[17]});
    // Upper lane only: the pointer's low byte must survive the write
    wsel = 4'h2;
    wb(1'b1, 8'h44, 32'h0000_5A00);
    wsel = 4'hF;
    shadow[17][15:8] = 8'h5A;
    wb(1'b0, 8'h44, 32'h0000_0000);
    chk("byte lane", rd, {16'h0000, shadow[17]});
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    en = 6'h00;
    wb(1'b0, 8'h44, 32'h0000_0000);
    chk("cfg after reset", rd, {17'h0_0000, shadow[17][14:0]});
    final_report();
  end
endmodule : usb_endpoint_config_tb
